//--- logic/otss_output_select.sv
// terminal function selection for running, relay and second outputs
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - codes 70/170 route the loop output-interruption indication
// - codes 80/180 route the safety stop indication
// - codes 81/181 route not-safety-circuit-fault
// - codes 90/190 life alarm from capacitor, inrush or fan wear
// - codes 91/191 route the power-off fault indication
// - codes 93/193 route the current pulse train; refused on the relay
// - codes 95/195 assert when timer count reaches the threshold
// - codes 96/196 drive the terminal from the remote bit
// - codes 98/198 light alarm on fan failure or communication warning
// - codes 99/199 trip indication held until fault reset
// - lower codes conduct when active, upper codes do not
// - one code may drive several terminals at once
// - ready (11/111) on whenever the drive can run, also running
// - running (0/100) from starting frequency, off stopped or braking
// - restart: running off coasting, on restarting; ready drops on power loss
// - running terminal resets to running indication, normal polarity
// - relay resets to trip indication; trip may move elsewhere
// - power-off fault from the six listed internal faults
// - second terminal resets to safety stop, relay to trip
// - no-function code refused on second terminal only
module otss_output_select
  import otss_pkg::*;
#(
  parameter int TIMER_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // drive state
  input wire otss_drive_type drive,
  input wire otss_pwroff_type pwroff_src,
  input wire otss_status_type status,
  input wire logic [TIMER_W-1:0] maintenance_timer_count,
  input wire logic [TIMER_W-1:0] maintenance_alarm_threshold,
  // terminals: running, relay, second
  output logic running_terminal,
  output logic relay_changeover_contact,
  output logic second_terminal,
  // indications
  output otss_ind_type ind
);

  otss_state_type s_r, s_nxt;
  logic running, drive_ready, maint, life_alarm, light_alarm_out;
  logic wr, rd, fault_clr, pwroff_now;

  // code validity per terminal; 9999 only on the first two
  function automatic logic code_ok(input logic [13:0] code, input logic is_relay,
                                   input logic is_second);
    logic ok;
    ok = (code <= CODE_MAX) || (code == CODE_NONE && !is_second);
    if (is_relay && (code == F_AVGCUR || code == F_AVGCUR + POL_BASE)) begin
      ok = 1'b0;
    end
    return ok;
  endfunction

  // map a code to the terminal level; shared by all terminals
  function automatic logic term_level(input logic [13:0] code, input logic [15:0] sig);
    logic [13:0] base;
    logic pol;
    logic v;
    pol = (code >= POL_BASE) && (code != CODE_NONE);
    base = pol ? code - POL_BASE : code;
    v = 1'b0;
    unique case (base)
      F_RUN: v = sig[0];
      F_FREQ_REACHED: v = sig[1];
      F_READY: v = sig[2];
      F_SLEEP: v = sig[3];
      F_SAFE: v = sig[4];
      F_SAFETY_MONITOR_OUT_SECOND: v = sig[5];
      F_LIFE: v = sig[6];
      F_PWROFF: v = sig[7];
      F_AVGCUR: v = sig[8];
      F_MAINT: v = sig[9];
      F_REMOTE: v = sig[10];
      F_LIGHT: v = sig[11];
      F_TRIP: v = sig[12];
      default: v = 1'b0; // unassigned codes below 100 and 9999 never conduct; unassigned codes from 100 up always do
    endcase
    if (code == CODE_NONE) begin
      return 1'b0;
    end
    return v ^ pol;
  endfunction

  // drive condition indications
  always_comb begin
    // on above start frequency or while restarting
    running = (drive.freq_at_start || drive.restarting) && !drive.dc_brake
              && !drive.restart_coasting && !drive.fault && !drive.output_shutoff_command;
    // ready unless fault, shutoff or power loss
    drive_ready = !drive.fault && !drive.output_shutoff_command && !drive.power_loss;
    maint = maintenance_timer_count >= maintenance_alarm_threshold;
    life_alarm = status.cap_life || status.inrush_life || status.fan_life;
    light_alarm_out = status.fan_failure || status.comm_error;
    pwroff_now = |pwroff_src;
  end

  // apb decode; zero wait states
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign fault_clr = wr && paddr == REG_FAULT_CLR && pwdata[0];
  assign pready = psel && penable;
  assign pslverr = 1'b0;

  // next state
  always_comb begin
    logic [15:0] sig;
    logic [13:0] code;
    s_nxt = s_r;
    sig = '0;
    code = pwdata[13:0];
    // trip and power-off latch; set wins over a clear in the same cycle
    s_nxt.trip = drive.fault || (s_r.trip && !fault_clr);
    s_nxt.pwroff = pwroff_now || (s_r.pwroff && !fault_clr);
    // selection writes act next cycle; illegal codes keep old value
    if (wr) begin
      unique case (paddr)
        REG_RUN_SEL: begin
          if (code_ok(code, 1'b0, 1'b0)) s_nxt.run_sel = code;
          s_nxt.reject[0] = !code_ok(code, 1'b0, 1'b0);
        end
        REG_RELAY_SEL: begin
          if (code_ok(code, 1'b1, 1'b0)) s_nxt.relay_sel = code;
          s_nxt.reject[1] = !code_ok(code, 1'b1, 1'b0);
        end
        REG_SECOND_SEL: begin
          if (code_ok(code, 1'b0, 1'b1)) s_nxt.second_sel = code;
          s_nxt.reject[2] = !code_ok(code, 1'b0, 1'b1);
        end
        REG_REMOTE: s_nxt.remote_out = pwdata[0];
        default: ;
      endcase
    end
    // shared signal vector so one code can feed several terminals
    sig[0] = running;
    sig[1] = drive.frequency_reached;
    sig[2] = drive_ready;
    sig[3] = status.loop_interrupt;
    sig[4] = status.safety_stop;
    sig[5] = !status.safety_circuit_fault;
    sig[6] = life_alarm;
    sig[7] = s_r.pwroff;
    sig[8] = status.avg_current_pulse;
    sig[9] = maint;
    sig[10] = s_r.remote_out;
    sig[11] = light_alarm_out;
    sig[12] = s_r.trip;
    s_nxt.term[0] = term_level(s_r.run_sel, sig);
    s_nxt.term[1] = term_level(s_r.relay_sel, sig);
    s_nxt.term[2] = term_level(s_r.second_sel, sig);
    // read data
    s_nxt.prdata = '0;
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        REG_RUN_SEL: s_nxt.prdata[13:0] = s_r.run_sel;
        REG_RELAY_SEL: s_nxt.prdata[13:0] = s_r.relay_sel;
        REG_SECOND_SEL: s_nxt.prdata[13:0] = s_r.second_sel;
        REG_REMOTE: s_nxt.prdata[0] = s_r.remote_out;
        REG_STATUS: begin
          s_nxt.prdata[ST_RUN] = running;
          s_nxt.prdata[ST_READY] = drive_ready;
          s_nxt.prdata[ST_TRIP] = s_r.trip;
          s_nxt.prdata[ST_PWROFF] = s_r.pwroff;
          s_nxt.prdata[ST_TERM0] = s_r.term[0];
          s_nxt.prdata[ST_TERM1] = s_r.term[1];
          s_nxt.prdata[ST_TERM2] = s_r.term[2];
        end
        REG_REJECT: s_nxt.prdata[2:0] = s_r.reject;
        default: ;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.run_sel <= RST_RUN_SEL;
      s_r.relay_sel <= RST_RELAY_SEL;
      s_r.second_sel <= RST_SECOND_SEL;
    end else begin
      s_r <= s_nxt;
    end
  end

  // terminal outputs from flip-flops; the relay sees a registered level only
  assign running_terminal = s_r.term[0];
  assign relay_changeover_contact = s_r.term[1];
  assign second_terminal = s_r.term[2];
  assign prdata = rd ? s_r.prdata : '0;
  assign ind.running = running;
  assign ind.drive_ready = drive_ready;
  assign ind.trip_indication = s_r.trip;
  assign ind.power_off_fault_out = s_r.pwroff;

endmodule

`default_nettype wire

//--- logic/otss_pkg.sv
// package for the output terminal signal select block
package otss_pkg;

  // selection code width and polarity split
  localparam int SEL_W = 14;
  localparam logic [13:0] POL_BASE = 14'h0064; // 100: codes from here are inverted
  localparam logic [13:0] CODE_MAX = 14'h00c7; // 199: highest assignable code
  localparam logic [13:0] CODE_NONE = 14'h270f; // 9999: no function

  // positive-logic function codes
  localparam logic [13:0] F_RUN = 14'h0000;
  localparam logic [13:0] F_FREQ_REACHED = 14'h0001;
  localparam logic [13:0] F_READY = 14'h000b;
  localparam logic [13:0] F_SLEEP = 14'h0046;
  localparam logic [13:0] F_SAFE = 14'h0050;
  localparam logic [13:0] F_SAFETY_MONITOR_OUT_SECOND = 14'h0051;
  localparam logic [13:0] F_LIFE = 14'h005a;
  localparam logic [13:0] F_PWROFF = 14'h005b;
  localparam logic [13:0] F_AVGCUR = 14'h005d;
  localparam logic [13:0] F_MAINT = 14'h005f;
  localparam logic [13:0] F_REMOTE = 14'h0060;
  localparam logic [13:0] F_LIGHT = 14'h0062;
  localparam logic [13:0] F_TRIP = 14'h0063;

  // reset values of the three selection registers
  localparam logic [13:0] RST_RUN_SEL = F_RUN;
  localparam logic [13:0] RST_RELAY_SEL = F_TRIP;
  localparam logic [13:0] RST_SECOND_SEL = F_SAFE;

  // apb register offsets (byte addresses)
  localparam logic [7:0] REG_RUN_SEL = 8'h00;
  localparam logic [7:0] REG_RELAY_SEL = 8'h04;
  localparam logic [7:0] REG_SECOND_SEL = 8'h08;
  localparam logic [7:0] REG_REMOTE = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_FAULT_CLR = 8'h14;
  localparam logic [7:0] REG_REJECT = 8'h18;

  // status register bit positions
  localparam int ST_RUN = 0;
  localparam int ST_READY = 1;
  localparam int ST_TRIP = 2;
  localparam int ST_PWROFF = 3;
  localparam int ST_TERM0 = 4;
  localparam int ST_TERM1 = 5;
  localparam int ST_TERM2 = 6;

  // drive condition inputs
  typedef struct packed {
    logic freq_at_start;          // output frequency >= starting frequency
    logic dc_brake;               // dc injection braking
    logic start_cmd;              // start signal present
    logic output_shutoff_command; // output shutoff input
    logic fault;                  // any fault detected
    logic power_loss;             // power loss or undervoltage
    logic restart_coasting;       // auto restart, coasting phase
    logic restarting;             // auto restart, restart phase
    logic frequency_reached;      // frequency reached
  } otss_drive_type;

  // fault sources for the power-off indication
  typedef struct packed {
    logic brake_transistor_fault;
    logic earth_fault_at_start;
    logic output_phase_loss_fault;
    logic param_storage_fault;
    logic processor_fault;
    logic inrush_limit_fault;
  } otss_pwroff_type;

  // status sources routed to terminals
  typedef struct packed {
    logic loop_interrupt;         // loop controller output interruption
    logic safety_stop;            // safety stop active
    logic safety_circuit_fault;   // safety circuit fault active
    logic cap_life;               // capacitor near end of life
    logic inrush_life;            // inrush limit circuit near end of life
    logic fan_life;               // fan near end of life
    logic avg_current_pulse;      // averaged current / timer pulse train
    logic fan_failure;            // fan failure warning
    logic comm_error;             // communication error warning
  } otss_status_type;

  // remaining terminal-facing outputs
  typedef struct packed {
    logic running;
    logic drive_ready;
    logic trip_indication;
    logic power_off_fault_out;
  } otss_ind_type;

  // all module state
  typedef struct packed {
    logic [13:0] run_sel;
    logic [13:0] relay_sel;
    logic [13:0] second_sel;
    logic remote_out;
    logic trip;
    logic pwroff;
    logic [2:0] reject;
    logic [2:0] term;
    logic [31:0] prdata;
  } otss_state_type;

endpackage

//--- bench/otss_output_select_sva.sv
// assertion checker for the output terminal select block
`timescale 1ns/100ps
`default_nettype none
module otss_output_select_sva
  import otss_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // drive state and indications
  input wire otss_drive_type drive,
  input wire otss_pwroff_type pwroff_src,
  input wire otss_ind_type ind
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // fault clear write, with reset the only way out of a latched indication
  logic clr;
  assign clr = psel && penable && pwrite && paddr == REG_FAULT_CLR && pwdata[0];
  a_apb_no_wait: assert property (psel && !penable ##1 psel && penable |-> pready)
    else $error("pready late");
  a_apb_no_err: assert property (pready |-> !pslverr)
    else $error("pslverr set");
  a_ready_level: assert property (ind.drive_ready ==
    !(drive.fault || drive.output_shutoff_command || drive.power_loss))
    else $error("ready wrong");
  a_run_level: assert property (ind.running ==
    ((drive.freq_at_start || drive.restarting) && !drive.dc_brake && !drive.restart_coasting
    && !drive.fault && !drive.output_shutoff_command)) else $error("running wrong");
  a_trip_set: assert property (drive.fault |=> ind.trip_indication)
    else $error("trip not set");
  a_trip_hold: assert property (ind.trip_indication && !clr |=> ind.trip_indication)
    else $error("trip lost");
  a_trip_quiet: assert property (!ind.trip_indication && !drive.fault
    |=> !ind.trip_indication) else $error("trip spurious");
  a_pwroff_set: assert property ((|pwroff_src) |=> ind.power_off_fault_out)
    else $error("pwroff not set");
  a_pwroff_quiet: assert property (!ind.power_off_fault_out && !(|pwroff_src)
    |=> !ind.power_off_fault_out) else $error("pwroff spurious");
endmodule
bind otss_output_select otss_output_select_sva u_sva (.clk, .nrst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .drive, .pwroff_src, .ind);
`default_nettype wire

//--- bench/otss_load_model.sv
// external loads wired to the three output terminals
`timescale 1ns/100ps
`default_nettype none
module otss_load_model (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // terminals
  input wire logic run_t,
  input wire logic relay_t,
  input wire logic sec_t,
  // relay switching count
  output var logic [15:0] toggles
);
  logic relay_q;
  // each relay change wears the contact, so the bench keeps changes few
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      relay_q <= 1'b0;
      toggles <= 16'h0;
    end else begin
      relay_q <= relay_t;
      toggles <= toggles + 16'(relay_q != relay_t);
    end
  end
endmodule
`default_nettype wire

//--- bench/otss_output_select_tb.sv
// testbench for the output terminal select block
`timescale 1ns/100ps
`default_nettype none
module otss_output_select_tb
  import otss_pkg::*;
;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, run_t, relay_t, sec_t;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  otss_drive_type drv;
  otss_pwroff_type pw;
  otss_status_type st;
  otss_ind_type ind;
  logic [15:0] cnt, thr, toggles;
  int err_count, checks;
  logic [13:0] codes [13] = '{14'h0, 14'h01, 14'h0b, 14'h46, 14'h50, 14'h51, 14'h5a, 14'h5d,
    14'h5b, 14'h5f, 14'h60, 14'h62, 14'h63};
  logic [2:0] terms;
  assign terms = {run_t, relay_t, sec_t}; // all three terminal levels
  logic [8:0] pat [4] = '{9'h180, 9'h104, 9'h002, 9'h00a};
  logic [1:0] ev [4] = '{2'h1, 2'h1, 2'h3, 2'h2};

  otss_output_select #(.TIMER_W(16)) dut (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .drive(drv), .pwroff_src(pw), .status(st),
    .maintenance_timer_count(cnt), .maintenance_alarm_threshold(thr),
    .running_terminal(run_t), .relay_changeover_contact(relay_t), .second_terminal(sec_t),
    .ind(ind));
  otss_load_model u_load (.clk(clk), .nrst(nrst), .run_t(run_t), .relay_t(relay_t),
    .sec_t(sec_t), .toggles(toggles));

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; read data lands in rd at the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task test_done;
    if (err_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // watchdog, far beyond the roughly 660 cycles the tests need
  initial begin
    #200us;
    err_count++;
    test_done;
  end

  // main sequence
  initial begin
    nrst = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    drv = 9'h100;
    st = 9'h080;
    pw = '0;
    cnt = 16'h4;
    thr = 16'h5;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    chk(32'({run_t, relay_t, sec_t}), 32'h5);
    apb(1'b0, REG_RUN_SEL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'h53);
    apb(1'b0, REG_RELAY_SEL, 32'h0);
    chk(rd, 32'h63);
    apb(1'b0, REG_SECOND_SEL, 32'h0);
    chk(rd, 32'h50);
    // phase 0 holds every source idle, phase 1 every source active
    for (int ph = 0; ph < 2; ph++) begin
      @(posedge clk);
      st <= ph ? 9'h1bf : 9'h040;
      drv <= ph ? 9'h111 : 9'h020;
      pw <= ph ? 6'h01 : 6'h00;
      cnt <= ph ? 16'h5 : 16'h4;
      @(posedge clk);
      // frequency reached stays up so code 1/101 follows the phase too
      drv <= ph ? 9'h101 : 9'h020;
      pw <= '0;
      apb(1'b1, REG_REMOTE, 32'(ph));
      apb(1'b0, REG_REMOTE, 32'h0);
      chk(rd, 32'(ph));
      for (int pol = 0; pol < 2; pol++) begin
        for (int i = 0; i < 13; i++) begin
          apb(1'b1, REG_RUN_SEL, 32'(codes[i] + 14'h64 * pol));
          apb(1'b1, REG_RELAY_SEL, 32'(codes[i] + 14'h64 * pol));
          apb(1'b1, REG_SECOND_SEL, 32'(codes[i] + 14'h64 * pol));
          repeat (2) @(posedge clk);
          chk(32'(terms), 32'(7 * (ph ^ pol)));
        end
      end
    end
    chk(32'(ind.trip_indication), 32'h1);
    apb(1'b1, REG_RELAY_SEL, 32'h5d);
    apb(1'b1, REG_SECOND_SEL, 32'h270f);
    apb(1'b1, REG_RUN_SEL, 32'h270f);
    apb(1'b0, REG_REJECT, 32'h0);
    chk(rd, 32'h6);
    apb(1'b0, REG_RELAY_SEL, 32'h0);
    chk(rd, 32'hc7);
    apb(1'b0, REG_RUN_SEL, 32'h0);
    chk(rd, 32'h270f);
    apb(1'b0, 8'h1c, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, REG_FAULT_CLR, 32'h1);
    repeat (2) @(posedge clk);
    chk(32'({ind.trip_indication, ind.power_off_fault_out}), 32'h0);
    // braking, coasting, restarting and power loss
    for (int k = 0; k < 4; k++) begin
      drv <= pat[k];
      repeat (2) @(posedge clk);
      chk(32'({ind.running, ind.drive_ready}), 32'(ev[k]));
    end
    chk(32'(toggles < 16'h40), 32'h1);
    // a reset in mid-run must bring the run and relay selections back to their initial codes
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    chk(32'(terms), 32'h5);
    apb(1'b0, REG_RUN_SEL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, REG_RELAY_SEL, 32'h0);
    chk(rd, 32'h63);
    test_done;
  end
endmodule
`default_nettype wire
